// ==== interval_consts.svh ====
// Timing and sizing constants for the gated interval counter.
// Assumes a single 250 MHz time-base clock drives the whole block.
`ifndef INTERVAL_CONSTS_SVH
`define INTERVAL_CONSTS_SVH

// ==========================================================
// Time base
`define CLK_PERIOD_PS 4000
`define CLK_PERIOD_NS 4

// ==========================================================
// Dead time after a stop, in ns, and its cycle count (rounded up)
`define DEAD_TIME_NS 150
`define DEAD_CYCLES ((`DEAD_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define DEAD_W 8

// ==========================================================
// Least start-to-stop interval, in time-base periods
`define MIN_INTERVAL_CYCLES 1

// ==========================================================
// Averaging: N = 2**avg_log2, avg_log2 at most this value
`define AVG_LOG2_W 4
`define AVG_LOG2_MAX 8
`define AVG_N_W 9
`define ACC_EXTRA_W 8
`define RES_EXTRA_W 3

`endif

// ==== interval_pkg.sv ====
// Types shared by the gated interval counter.
// Assumes interval_consts.svh supplies the numeric constants.
package interval_pkg;

    // ======================================================
    // Gate state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_GATE = 2'b01,
        ST_DEAD = 2'b10
    } gate_state_t;

endpackage : interval_pkg

// ==== pulse_source.sv ====
// Behavioural start/stop source for the gated interval counter.
// Assumes it is clocked by the time base and commanded by the bench.
`timescale 1ns/1ps

module pulse_source (
    // Clock
    input wire logic i_core_clk,
    // Command
    input wire logic i_go,
    input wire logic [7:0] i_gap,
    // Event channels
    output logic o_start,
    output logic o_stop
);
    // ==========================================================
    // Pair generator
    // Pulses three cycles wide so the synchronisers see them
    int t = 300;
    always @(negedge i_core_clk) begin
        if (i_go) begin
            t <= 0;
        end else if (t < 300) begin
            t <= t + 1;
        end
        o_start <= (t >= 0) && (t < 3);
        o_stop <= (t >= int'(i_gap)) && (t < int'(i_gap) + 3);
    end
endmodule : pulse_source

// ==== time_interval_counter.sv ====
// Gated time-interval counter: start pulse opens the gate, stop closes it.
// Assumes start and stop arrive asynchronously as clean one-per-event levels.
//
// Summary of operation
// [RL1] A start edge on the first channel opens the counting gate.
// [RL2] A later accepted stop edge on the second channel closes the gate.
// [RL3] The interval counter steps once on every time-base cycle while the gate is open.
// [RL4] One count equals one time-base period, 4 ns at 250 MHz.
// [RL5] An accepted interval is always at least one full time-base period.
// [RL6] After a stop, start edges are ignored until the dead time has run out.
// [RL7] A stop earlier than the least interval is ignored and the gate stays open.
// [RL8] The result is the count multiplied by the clock period in ns.
// [RL9] A direct mode gives the raw count in clock periods for unscaled readout.
// [RL10] Start and stop pass synchronisers into the gate logic; the clock may be noise modulated.
// [RL11] Sub-period averaging needs the source to repeat start/stop pairs.
// [RL12] The counter clears as the gate opens; averaging sums N intervals and divides by N.
// [RL13] A result is posted only after the gate closes and holds until the next one.
`timescale 1ns/1ps
`include "interval_consts.svh"

module time_interval_counter #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Event channels (asynchronous)
    input wire logic i_start,
    input wire logic i_stop,
    // Mode controls (same clock domain)
    input wire logic i_avg_en,
    input wire logic [`AVG_LOG2_W-1:0] i_avg_log2,
    input wire logic i_direct,
    // Status
    output logic o_gate_open,
    output logic o_dead_time,
    // Result
    output logic [CNT_W-1:0] o_elapsed_interval,
    output logic [CNT_W+`RES_EXTRA_W-1:0] o_result,
    output logic o_result_valid
);

    localparam int ACC_W = CNT_W + `ACC_EXTRA_W;
    localparam int RES_W = CNT_W + `RES_EXTRA_W;

    typedef struct packed {
        interval_pkg::gate_state_t st;
        logic [2:0] sync_start;
        logic [2:0] sync_stop;
        logic [CNT_W-1:0] cnt;
        logic [ACC_W-1:0] acc;
        logic [`AVG_N_W-1:0] n_done;
        logic [`DEAD_W-1:0] dead_cnt;
        logic [CNT_W-1:0] raw;
        logic [RES_W-1:0] result;
        logic valid;
    } state_t;

    // ======================================================
    // Reset release
    logic rst_meta_ff;
    logic rst_n_ff;

    // Release is synchronous so no flop leaves reset ahead of the others
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ======================================================
    // State
    state_t s_ff;
    state_t nxt_s;

    logic start_edge;
    logic stop_edge;
    logic stop_ok;
    logic [CNT_W-1:0] cnt_now;
    logic last_of_set;
    logic [`AVG_LOG2_W-1:0] shift_amt;
    logic [`AVG_N_W-1:0] n_target;
    logic [ACC_W-1:0] acc_sum;
    logic [ACC_W-1:0] acc_avg;
    logic [RES_W-1:0] avg_res;

    // Edges taken from stages two and three only; stage one is metastable
    assign start_edge = s_ff.sync_start[1] & ~s_ff.sync_start[2]; // [RL10]
    assign stop_edge = s_ff.sync_stop[1] & ~s_ff.sync_stop[2]; // [RL10]
    // Cycles the gate has been open, this one included; wraps with no flag
    assign cnt_now = s_ff.cnt + CNT_W'(1); // [RL3]
    // A stop in the very cycle of the start is seen in idle and so ignored
    assign stop_ok = stop_edge && (cnt_now >= CNT_W'(`MIN_INTERVAL_CYCLES)); // [RL5] [RL7]

    // Power-of-two N keeps the divide a plain shift
    assign shift_amt = (i_avg_log2 > `AVG_LOG2_W'(`AVG_LOG2_MAX)) ?
        `AVG_LOG2_W'(`AVG_LOG2_MAX) : i_avg_log2;
    assign n_target = i_avg_en ? (`AVG_N_W'(1) << shift_amt) : `AVG_N_W'(1);
    assign last_of_set = (s_ff.n_done + `AVG_N_W'(1)) >= n_target;
    assign acc_sum = s_ff.acc + ACC_W'(cnt_now); // [RL12]
    assign acc_avg = i_avg_en ? (acc_sum >> shift_amt) : acc_sum; // [RL12]
    assign avg_res = RES_W'(acc_avg[CNT_W-1:0]);

    always_comb begin
        nxt_s = s_ff;
        nxt_s.sync_start = {s_ff.sync_start[1:0], i_start};
        nxt_s.sync_stop = {s_ff.sync_stop[1:0], i_stop};
        nxt_s.valid = 1'b0;
        unique case (s_ff.st)
            interval_pkg::ST_IDLE: begin
                if (start_edge) begin
                    nxt_s.st = interval_pkg::ST_GATE; // [RL1]
                    nxt_s.cnt = '0; // [RL12]
                    if (s_ff.n_done == '0) begin
                        nxt_s.acc = '0; // [RL12]
                    end
                end
            end
            interval_pkg::ST_GATE: begin
                if (stop_ok) begin
                    nxt_s.st = interval_pkg::ST_DEAD; // [RL2]
                    nxt_s.dead_cnt = `DEAD_W'(`DEAD_CYCLES); // [RL6]
                    nxt_s.raw = cnt_now; // [RL3]
                    if (last_of_set) begin
                        nxt_s.n_done = '0;
                        nxt_s.acc = '0;
                        nxt_s.valid = 1'b1; // [RL13]
                        if (i_direct) begin
                            nxt_s.result = avg_res; // [RL9]
                        end else begin
                            nxt_s.result = RES_W'(avg_res * RES_W'(`CLK_PERIOD_NS)); // [RL4] [RL8]
                        end
                    end else begin
                        nxt_s.n_done = s_ff.n_done + `AVG_N_W'(1); // [RL12]
                        nxt_s.acc = acc_sum;
                    end
                end else begin
                    nxt_s.cnt = cnt_now; // [RL3]
                end
            end
            interval_pkg::ST_DEAD: begin
                // Starts are simply not looked at here
                if (s_ff.dead_cnt <= `DEAD_W'(1)) begin
                    nxt_s.st = interval_pkg::ST_IDLE; // [RL6]
                end else begin
                    nxt_s.dead_cnt = s_ff.dead_cnt - `DEAD_W'(1);
                end
            end
            default: begin
                nxt_s.st = interval_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ======================================================
    // Outputs
    assign o_gate_open = (s_ff.st == interval_pkg::ST_GATE);
    assign o_dead_time = (s_ff.st == interval_pkg::ST_DEAD);
    assign o_elapsed_interval = s_ff.raw;
    assign o_result = s_ff.result; // [RL13]
    assign o_result_valid = s_ff.valid;

    // ======================================================
    // Checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!rst_n_ff);

    AST_GATE_OPENS: assert property ( // [RL1]
        (s_ff.st == interval_pkg::ST_IDLE) && start_edge |=> o_gate_open && (s_ff.cnt == '0))
        else $error("gate did not open on start");

    AST_GATE_CLOSES: assert property ( // [RL2]
        o_gate_open && stop_ok |=> o_dead_time && (s_ff.raw == $past(s_ff.cnt) + CNT_W'(1)))
        else $error("gate did not close on stop");

    AST_COUNT_STEPS: assert property ( // [RL3]
        o_gate_open && !stop_ok |=> o_gate_open && (s_ff.cnt == $past(s_ff.cnt) + CNT_W'(1)))
        else $error("count did not step while gate open");

    AST_MIN_INTERVAL: assert property ( // [RL5]
        o_result_valid && !i_avg_en |-> (o_elapsed_interval >= CNT_W'(`MIN_INTERVAL_CYCLES)))
        else $error("interval below one period accepted");

    AST_EARLY_STOP_IGNORED: assert property ( // [RL7]
        (s_ff.st == interval_pkg::ST_IDLE) && start_edge && stop_edge |=> o_gate_open)
        else $error("early stop closed the gate");

    AST_DEAD_BLOCKS_START: assert property ( // [RL6]
        o_dead_time && (s_ff.dead_cnt > `DEAD_W'(1)) |=> o_dead_time && !o_gate_open)
        else $error("dead time cut short");

    AST_DEAD_LOADED: assert property ( // [RL6]
        $rose(o_dead_time) |-> (s_ff.dead_cnt == `DEAD_W'(`DEAD_CYCLES)))
        else $error("dead time not loaded");

    AST_SCALED: assert property ( // [RL8]
        o_result_valid && !$past(i_direct) && !$past(i_avg_en) |->
        (o_result == RES_W'(RES_W'(o_elapsed_interval) * RES_W'(`CLK_PERIOD_NS))))
        else $error("scaled result wrong");

    AST_VALID_AFTER_CLOSE: assert property ( // [RL13]
        o_result_valid |-> o_dead_time && ($past(s_ff.st) == interval_pkg::ST_GATE))
        else $error("result posted without gate close");

    AST_RESULT_HELD: assert property ( // [RL13]
        !o_result_valid |-> $stable(o_result))
        else $error("result changed between measurements");

    // ======================================================
    // Checks: gate open and close

    AST_IDLE_HOLDS: assert property ( // [RL1]
        (s_ff.st == interval_pkg::ST_IDLE) && !start_edge
        |=> (s_ff.st == interval_pkg::ST_IDLE))
        else $error("gate left idle without a start");

    AST_STOP_ACCEPTED: assert property ( // [RL2] [RL5]
        o_gate_open && stop_edge && (s_ff.cnt >= CNT_W'(`MIN_INTERVAL_CYCLES - 1))
        |=> o_dead_time && !o_gate_open)
        else $error("timely stop did not close the gate");

    AST_GATE_HELD: assert property ( // [RL7]
        o_gate_open && !stop_edge
        |=> o_gate_open)
        else $error("gate closed without a stop");

    AST_CNT_OUTSIDE: assert property ( // [RL3]
        !o_gate_open && !((s_ff.st == interval_pkg::ST_IDLE) && start_edge)
        |=> $stable(s_ff.cnt))
        else $error("count moved while gate shut");

    // ======================================================
    // Checks: dead time

    AST_DEAD_COUNTS: assert property ( // [RL6]
        o_dead_time && (s_ff.dead_cnt > `DEAD_W'(1))
        |=> (s_ff.dead_cnt == $past(s_ff.dead_cnt) - `DEAD_W'(1)))
        else $error("dead time did not count down");

    AST_DEAD_ENDS: assert property ( // [RL6]
        o_dead_time && (s_ff.dead_cnt <= `DEAD_W'(1))
        |=> (s_ff.st == interval_pkg::ST_IDLE))
        else $error("dead time overran");

    AST_START_IN_DEAD: assert property ( // [RL6]
        o_dead_time && start_edge
        |=> !o_gate_open)
        else $error("start accepted in dead time");

    // ======================================================
    // Checks: results and averaging

    AST_DIRECT: assert property ( // [RL9]
        o_result_valid && $past(i_direct) && !$past(i_avg_en)
        |-> (o_result == RES_W'(o_elapsed_interval)))
        else $error("direct result not the raw count");

    AST_VALID_PULSE: assert property ( // [RL13]
        o_result_valid
        |=> !o_result_valid)
        else $error("result valid longer than one cycle");

    AST_ELAPSED_HELD: assert property ( // [RL13]
        !$rose(o_dead_time)
        |-> $stable(o_elapsed_interval))
        else $error("interval changed without a close");

    AST_SINGLE_POSTS: assert property ( // [RL13]
        $rose(o_dead_time) && !$past(i_avg_en)
        |-> o_result_valid)
        else $error("single shot close posted no result");

    AST_SET_CLEARED: assert property ( // [RL12]
        o_result_valid
        |-> (s_ff.acc == '0) && (s_ff.n_done == '0))
        else $error("average set not cleared after posting");

    AST_ACC_FIRST_CLEARED: assert property ( // [RL12]
        (s_ff.st == interval_pkg::ST_IDLE) && start_edge && (s_ff.n_done == '0)
        |=> (s_ff.acc == '0))
        else $error("accumulator not cleared on first start");

    AST_PARTIAL_SET: assert property ( // [RL12]
        $rose(o_dead_time) && !o_result_valid
        |-> (s_ff.n_done != '0))
        else $error("unposted close not counted into set");

    // ======================================================
    // Scenarios covered
    COV_SINGLE: cover property (o_gate_open ##1 o_result_valid);
    COV_EARLY_STOP: cover property ((s_ff.st == interval_pkg::ST_IDLE) && start_edge && stop_edge);
    COV_START_IN_DEAD: cover property (o_dead_time && start_edge);
    COV_AVERAGE: cover property (o_result_valid && $past(i_avg_en) && ($past(i_avg_log2) != '0));
    COV_DIRECT: cover property (o_result_valid && $past(i_direct));

endmodule : time_interval_counter

// ==== time_interval_counter_tb.sv ====
// Self-checking bench for the gated interval counter.
// Assumes pulse_source supplies the event channels.
`timescale 1ns/1ps

module time_interval_counter_tb;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_avg_en = 1'b0;
    logic i_direct = 1'b0;
    logic go = 1'b0;
    logic [3:0] i_avg_log2 = 4'h0;
    logic [7:0] gap = 8'h00;
    logic i_start, i_stop, o_gate_open, o_dead_time, o_result_valid;
    logic [31:0] o_elapsed_interval;
    logic [34:0] o_result;
    int err_count = 0;
    int comparisons = 0;

    pulse_source pulse_source_i (.i_core_clk(i_core_clk), .i_go(go), .i_gap(gap),
        .o_start(i_start), .o_stop(i_stop));
    time_interval_counter time_interval_counter_i (.i_core_clk(i_core_clk),
        .i_rstn(i_rstn), .i_start(i_start), .i_stop(i_stop), .i_avg_en(i_avg_en),
        .i_avg_log2(i_avg_log2), .i_direct(i_direct), .o_gate_open(o_gate_open),
        .o_dead_time(o_dead_time), .o_elapsed_interval(o_elapsed_interval),
        .o_result(o_result), .o_result_valid(o_result_valid));

    initial forever #2 i_core_clk = ~i_core_clk;

    // ==========================================================
    // Shared tasks
    task conclude;
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    task check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task fire(input logic [7:0] g);
        @(negedge i_core_clk);
        // Non-blocking: the source samples the old values on this edge and sees these on the next negedge
        gap <= g;
        go <= 1'b1;
        @(negedge i_core_clk);
        go <= 1'b0;
    endtask : fire

    task await_valid;
        int n;
        n = 0;
        while (o_result_valid !== 1'b1) begin
            @(negedge i_core_clk);
            n++;
            if (n > 400) begin
                err_count++;
                conclude();
            end
        end
    endtask : await_valid

    // ==========================================================
    // Scenarios
    // Wait for the posted result, judge it and the dead time behind it
    task judge(input logic [34:0] res, input logic [31:0] el);
        int n;
        await_valid();
        check(o_elapsed_interval, el);
        check(o_result, res);
        check(o_gate_open, 1'b0);
        n = 0;
        while (o_dead_time === 1'b1 && n < 100) begin
            n++;
            @(negedge i_core_clk);
        end
        check(n, 38);
        if (n >= 100) begin
            conclude();
        end else begin
            check(o_result_valid, 1'b0);
            check(o_result, res);
        end
    endtask : judge

    task single(input logic [7:0] g, input logic d, input logic [34:0] res,
                input logic [31:0] el);
        i_direct = d;
        fire(g);
        judge(res, el);
    endtask : single

    // Stop together with start is too early; a stop 17 cycles on ends it
    task early_stop;
        i_direct = 1'b0;
        fire(8'h00);
        repeat (10) @(negedge i_core_clk);
        check(o_gate_open, 1'b1);
        fire(8'h05);
        judge(35'h44, 32'h11);
    endtask : early_stop

    // Start arriving inside the dead time must not open the gate
    task dead_start;
        int n;
        i_direct = 1'b0;
        fire(8'h14);
        await_valid();
        check(o_elapsed_interval, 32'h14);
        fire(8'hfa);
        n = 0;
        repeat (260) begin
            @(negedge i_core_clk);
            if (o_gate_open !== 1'b0) n++;
        end
        check(n, 0);
    endtask : dead_start

    // Two intervals of 6 and 9 average to 7, scaled to 28 ns
    task average_pair;
        int n;
        i_avg_en = 1'b1;
        i_avg_log2 = 4'h1;
        fire(8'h06);
        n = 0;
        repeat (50) begin
            @(negedge i_core_clk);
            if (o_result_valid !== 1'b0) n++;
        end
        check(n, 0);
        single(8'h09, 1'b0, 35'h1c, 32'h9);
        i_avg_en = 1'b0;
    endtask : average_pair

    initial begin
        repeat (5) @(negedge i_core_clk);
        i_rstn = 1'b1;
        repeat (3) @(negedge i_core_clk);
        single(8'h0a, 1'b0, 35'h28, 32'ha);
        single(8'h01, 1'b1, 35'h1, 32'h1);
        dead_start();
        early_stop();
        average_pair();
        conclude();
    end
endmodule : time_interval_counter_tb
